// [blsc_pkg.sv]
// Constants for the step-up LED switch control block.
// Assumes a 250 MHz system clock and a 1 MHz oscillator period.
package blsc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ        = 250_000_000;
    localparam int OSC_FREQ_HZ        = 1_000_000;
    localparam int OSC_PERIOD_CYC     = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam int SHDN_DELAY_MS      = 12;
    // Shutdown delay counted in oscillator periods
    localparam int SHDN_DELAY_PERIODS = SHDN_DELAY_MS * (OSC_FREQ_HZ / 1000);
    localparam int OSC_CNT_W          = 8;
    localparam int LOW_CNT_W          = 16;

    // ----------------------------------------------------------------
    // Soft-start ramp
    // ----------------------------------------------------------------
    localparam int          SS_W           = 3;
    localparam logic [2:0]  SS_MIN         = 3'h0;
    localparam logic [2:0]  SS_MAX         = 3'h7;
    localparam int          SS_STEP_PERIODS = 64;
    localparam logic [5:0]  SS_STEP_LAST   = 6'h3f;

    // ----------------------------------------------------------------
    // Operating states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BLSC_OFF   = 2'b00,
        BLSC_RUN   = 2'b01,
        BLSC_PAUSE = 2'b11
    } blsc_state_type;

endpackage

// [blsc_low_timer.sv]
// Shutdown-input low-time timer.
// Counts oscillator periods while the shutdown input stays low.
`timescale 1ns/1ps
module blsc_low_timer #(
    parameter int LIMIT = blsc_pkg::SHDN_DELAY_PERIODS
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic level_i,
    input  wire logic tick_i,
    output logic      expired_o
);

    logic [blsc_pkg::LOW_CNT_W-1:0] count;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count     <= '0;
            expired_o <= 1'b0;
        end
        else if (level_i)
        begin
            count     <= '0;
            expired_o <= 1'b0;
        end
        else if (tick_i && !expired_o)
        begin
            if (count == blsc_pkg::LOW_CNT_W'(LIMIT - 1))
                expired_o <= 1'b1;
            count <= count + 1'b1;
        end
    end

endmodule

// [blsc_ctrl.sv]
// Switch control of a current-mode step-up LED driver.
// Comparator flags and enables are synchronous to mclk_i.
// Function
// - Each oscillator period starts by setting the driver latch unless blocked.
// - PWM comparator trip resets the latch, switch off.
// - Duty limiter always forces the switch off before a period ends.
// - Light-load indication skips pulses.
// - Shutdown high, both enables low: low quiescent, bypasses off, switch idle.
// - Low quiescent entry resets soft-start.
// - Main high, sub low: sub bypass on, main bypass off, switching.
// - Main low, sub high: main bypass on, sub bypass off, switching.
// - Both enables high: both bypasses off, switching.
// - Enable decoding is static; low-time rules govern PWM dimming.
// - Short low on shutdown input pauses switching, keeps soft-start.
// - Low longer than delay: shut down, reset soft-start, bypasses off.
// - Over-temperature forces the switch off.
// - Undervoltage disables the switch while asserted.
// - Overvoltage stops switching.
// - Current limit turns switch off for rest of period, retry next.
// - While overvoltage is on, no switching; resume when it clears.
`timescale 1ns/1ps
module blsc_ctrl (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       shutdown_ctrl_i,
    input  wire logic       main_segment_enable_i,
    input  wire logic       sub_segment_enable_i,
    input  wire logic       pwm_trip_i,
    input  wire logic       light_load_i,
    input  wire logic       current_limit_i,
    input  wire logic       over_temp_i,
    input  wire logic       undervoltage_guard_i,
    input  wire logic       overvoltage_guard_i,
    output logic            power_switch_o,
    output logic            main_bypass_switch_o,
    output logic            sub_bypass_switch_o,
    output logic            period_start_o,
    output logic [2:0]      soft_start_level_o,
    output logic            shutdown_o,
    output logic            low_quiescent_o
);

    // ----------------------------------------------------------------
    // Oscillator
    // ----------------------------------------------------------------
    localparam logic [7:0] OSC_LAST = 8'(blsc_pkg::OSC_PERIOD_CYC - 1);

    logic [blsc_pkg::OSC_CNT_W-1:0] osc_cnt;
    logic                           osc_tick;
    logic                           duty_end;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            osc_cnt <= '0;
        else if (osc_cnt == OSC_LAST)
            osc_cnt <= '0;
        else
            osc_cnt <= osc_cnt + 1'b1;
    end

    assign osc_tick = (osc_cnt == OSC_LAST);
    // Duty limit lands one cycle before the period boundary so the switch
    // always shows at least one off cycle per period.
    assign duty_end = (osc_cnt == OSC_LAST - 8'h01);

    // ----------------------------------------------------------------
    // Shutdown low-time and operating state
    // ----------------------------------------------------------------
    logic                     low_expired;
    blsc_pkg::blsc_state_type state;
    blsc_pkg::blsc_state_type next_state;
    logic                     enables_low;
    logic                     quiescent;

    blsc_low_timer #(
        .LIMIT     (blsc_pkg::SHDN_DELAY_PERIODS)
    ) u_low_timer (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .level_i   (shutdown_ctrl_i),
        .tick_i    (osc_tick),
        .expired_o (low_expired)
    );

    assign enables_low = !main_segment_enable_i && !sub_segment_enable_i;
    assign quiescent   = shutdown_ctrl_i && enables_low;

    always_comb
    begin
        next_state = state;
        case (state)
            blsc_pkg::BLSC_OFF:
                if (shutdown_ctrl_i && !enables_low)
                    next_state = blsc_pkg::BLSC_RUN;
            blsc_pkg::BLSC_RUN:
                if (quiescent)
                    next_state = blsc_pkg::BLSC_OFF;
                else if (!shutdown_ctrl_i)
                    next_state = blsc_pkg::BLSC_PAUSE;
            blsc_pkg::BLSC_PAUSE:
                if (low_expired)
                    next_state = blsc_pkg::BLSC_OFF;
                else if (shutdown_ctrl_i)
                    next_state = enables_low ? blsc_pkg::BLSC_OFF
                                             : blsc_pkg::BLSC_RUN;
            default:
                next_state = blsc_pkg::BLSC_OFF;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state <= blsc_pkg::BLSC_OFF;
        else
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // Soft-start ramp
    // ----------------------------------------------------------------
    logic [5:0]               ss_div;
    logic [blsc_pkg::SS_W-1:0] ss_level;

    // Ramp restarts from minimum whenever the block is off and holds
    // during short pauses so PWM dimming recovers without inrush.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ss_div   <= '0;
            ss_level <= blsc_pkg::SS_MIN;
        end
        else if (state == blsc_pkg::BLSC_OFF)
        begin
            ss_div   <= '0;
            ss_level <= blsc_pkg::SS_MIN;
        end
        else if (state == blsc_pkg::BLSC_RUN && osc_tick &&
                 ss_level != blsc_pkg::SS_MAX)
        begin
            ss_div <= ss_div + 1'b1;
            if (ss_div == blsc_pkg::SS_STEP_LAST)
                ss_level <= ss_level + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Soft-start current limit: a pulse ends once its on time reaches
    // a level-dependent share of the period (32 clock cycles per step).
    // ----------------------------------------------------------------
    logic [7:0] ss_on_limit;
    logic       ss_trip;

    assign ss_on_limit = 8'({ss_level, 5'h00}) + 8'h1f;
    assign ss_trip     = (ss_level != blsc_pkg::SS_MAX) && (osc_cnt >= ss_on_limit);

    // ----------------------------------------------------------------
    // Driver latch
    // ----------------------------------------------------------------
    logic blocked;
    logic latch_set;
    logic latch_reset;
    logic limit_hit;

    // Protection flags block the set as well as reset the latch.
    assign blocked = over_temp_i
                  || undervoltage_guard_i
                  || overvoltage_guard_i
                  || quiescent
                  || state != blsc_pkg::BLSC_RUN
                  || light_load_i;

    // A trip or limit seen on the boundary cycle wins over the new set,
    // so the switch never turns on into a live comparator.
    assign latch_set   = osc_tick && !blocked
                      && !pwm_trip_i
                      && !current_limit_i;
    assign latch_reset = pwm_trip_i
                      || duty_end
                      || limit_hit
                      || ss_trip
                      || blocked;

    // Current limit stays latched until the next period boundary.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            limit_hit <= 1'b0;
        else if (osc_tick)
            limit_hit <= 1'b0;
        else if (current_limit_i)
            limit_hit <= 1'b1;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            power_switch_o <= 1'b0;
        else if (latch_set)
            power_switch_o <= 1'b1;
        else if (latch_reset || current_limit_i)
            power_switch_o <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Bypass switches and status
    // ----------------------------------------------------------------
    logic active;

    assign active = (state != blsc_pkg::BLSC_OFF);

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            main_bypass_switch_o <= 1'b0;
            sub_bypass_switch_o  <= 1'b0;
        end
        else
        begin
            main_bypass_switch_o <= active && !main_segment_enable_i
                                           && sub_segment_enable_i;
            sub_bypass_switch_o  <= active && main_segment_enable_i
                                           && !sub_segment_enable_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            period_start_o     <= 1'b0;
            soft_start_level_o <= blsc_pkg::SS_MIN;
            shutdown_o         <= 1'b1;
            low_quiescent_o    <= 1'b0;
        end
        else
        begin
            period_start_o     <= osc_tick;
            soft_start_level_o <= ss_level;
            shutdown_o         <= (state == blsc_pkg::BLSC_OFF) && !shutdown_ctrl_i;
            low_quiescent_o    <= quiescent;
        end
    end

endmodule

// [blsc_ctrl_chk.sv]
// Assertion checker for the LED switch control block.
// Assumes the block's own port names; bound at the foot of this file.
`timescale 1ns/1ps
module blsc_ctrl_chk (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic shutdown_ctrl_i,
    input wire logic main_segment_enable_i,
    input wire logic sub_segment_enable_i,
    input wire logic pwm_trip_i,
    input wire logic current_limit_i,
    input wire logic over_temp_i,
    input wire logic undervoltage_guard_i,
    input wire logic overvoltage_guard_i,
    input wire logic power_switch_o,
    input wire logic main_bypass_switch_o,
    input wire logic sub_bypass_switch_o,
    input wire logic shutdown_o,
    input wire logic low_quiescent_o
);
    wire        c  = shutdown_ctrl_i;
    wire        m  = main_segment_enable_i;
    wire        s  = sub_segment_enable_i;
    wire        p  = power_switch_o;
    wire        mb = main_bypass_switch_o;
    wire        sb = sub_bypass_switch_o;
    logic [7:0] on_cnt;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // Counts consecutive on cycles; a long pulse would saturate the coil
    always_ff @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i)
            on_cnt <= 8'h00;
        else
            on_cnt <= p ? on_cnt + 8'h01 : 8'h00;

    // ----
    // Switch
    // ----
    a_trip_off: assert property (pwm_trip_i |=> !p)
        else $error("switch on after trip");
    a_limit_off: assert property (current_limit_i |=> !p)
        else $error("switch on after limit");
    a_temp_off: assert property (over_temp_i |=> !p)
        else $error("switch on when hot");
    a_uv_off: assert property (undervoltage_guard_i |=> !p)
        else $error("switch on at low supply");
    a_ov_off: assert property (overvoltage_guard_i |=> !p)
        else $error("switch on at overvoltage");
    a_duty_limit: assert property (on_cnt <= 8'hf8)
        else $error("switch on too long");
    a_rise_run: assert property ($rose(p) |-> !shutdown_o && !low_quiescent_o)
        else $error("switch set while idle");

    // ----
    // Bypass decode
    // ----
    a_quiet_idle: assert property (low_quiescent_o |=> !mb && !sb)
        else $error("bypass on in quiescent");
    a_shut_idle: assert property (shutdown_o |-> !mb && !sb && !p)
        else $error("active in shutdown");
    a_sub_on: assert property ((c && m && !s)[*3] |=> sb && !mb)
        else $error("sub bypass decode");
    a_main_on: assert property ((c && !m && s)[*3] |=> mb && !sb)
        else $error("main bypass decode");
    a_both_off: assert property ((c && m && s)[*3] |=> !mb && !sb)
        else $error("full string decode");

    c_switch: cover property ($rose(p));
    c_quiet: cover property (low_quiescent_o);
    c_hot: cover property (over_temp_i && p);
endmodule

bind blsc_ctrl blsc_ctrl_chk i_blsc_ctrl_chk (.*);

// [blsc_host_model.sv]
// Host controller model driving the enable and dimming pins.
// Assumes the bench calls set_pins from its main sequence.
`timescale 1ns/1ps
module blsc_host_model #(
    parameter bit SUB_USED = 1'b1
) (
    input  wire logic mclk_i,
    output logic      shutdown_ctrl_o,
    output logic      main_o,
    output logic      sub_o
);
    initial
    begin
        shutdown_ctrl_o = 1'b0;
        main_o          = 1'b0;
        sub_o           = 1'b0;
    end

    // A low level on the control pin doubles as a dimming pause
    task automatic set_pins(input logic c, input logic m, input logic s);
        @(posedge mclk_i);
        shutdown_ctrl_o <= c;
        main_o          <= m;
        sub_o           <= s & SUB_USED;
    endtask
endmodule

// [blsc_ctrl_tb.sv]
// Self-checking bench for the LED switch control block.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
module blsc_ctrl_tb;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic [4:0] flt = 5'h00;
    logic       light = 1'b0;
    logic       c, m, s, p, mb, sb, sd, lq;
    logic [2:0] lvl;
    int         num_errors = 0;
    int         n_checks = 0;
    int         n;

    initial
        forever #2 mclk = ~mclk;

    blsc_host_model i_blsc_host_model (.mclk_i(mclk), .shutdown_ctrl_o(c),
        .main_o(m), .sub_o(s));
    blsc_ctrl i_blsc_ctrl (.mclk_i(mclk), .rst_n_i(rst_n), .shutdown_ctrl_i(c),
        .main_segment_enable_i(m), .sub_segment_enable_i(s), .pwm_trip_i(flt[0]),
        .light_load_i(light), .current_limit_i(flt[1]), .over_temp_i(flt[2]),
        .undervoltage_guard_i(flt[3]), .overvoltage_guard_i(flt[4]),
        .power_switch_o(p), .main_bypass_switch_o(mb), .sub_bypass_switch_o(sb),
        .period_start_o(), .soft_start_level_o(lvl), .shutdown_o(sd),
        .low_quiescent_o(lq));

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // Samples one step after the edge so that its updates have landed
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic count_on(input int k);
        n = 0;
        repeat (k)
        begin
            cyc(1);
            n += (p === 1'b1);
        end
    endtask

    task automatic wait_on();
        for (int i = 0; i < 1000 && p !== 1'b1; i++)
            cyc(1);
        if (p !== 1'b1)
        begin
            num_errors++;
            end_sim();
        end
    endtask

    initial
    begin
        cyc(2);
        chk(sd, 1'b1);
        @(posedge mclk) rst_n <= 1'b1;
        cyc(3);
        chk(sd, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            i_blsc_host_model.set_pins(1'b1, k[1], k[0]);
            cyc(4);
            chk(mb, !k[1] && k[0]);
            chk(sb, k[1] && !k[0]);
            chk(lq, !k[1] && !k[0]);
        end
        wait_on();
        count_on(40);
        chk(n > 0 && n <= 31, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            wait_on();
            @(posedge mclk) flt[i] <= 1'b1;
            @(posedge mclk) flt[i] <= 1'b0;
            count_on(100);
            chk(n, 0);
            wait_on();
        end
        @(posedge mclk) light <= 1'b1;
        count_on(600);
        chk(n, 0);
        @(posedge mclk) {light, flt[4]} <= 2'b01;
        count_on(600);
        chk(n, 0);
        @(posedge mclk) flt[4] <= 1'b0;
        wait_on();
        cyc(20000);
        chk(lvl, 3'h1);
        i_blsc_host_model.set_pins(1'b0, 1'b1, 1'b1);
        cyc(3);
        count_on(1000);
        chk(n, 0);
        chk({sd, lvl}, 4'h1);
        i_blsc_host_model.set_pins(1'b1, 1'b1, 1'b1);
        wait_on();
        i_blsc_host_model.set_pins(1'b1, 1'b0, 1'b0);
        cyc(4);
        chk(lvl, 3'h0);
        end_sim();
    end
endmodule
